/* File: eld_defines.svh */
// Constants for the lamp driver control core: offsets, bit positions, reset values, timing
`ifndef ELD_DEFINES_SVH
`define ELD_DEFINES_SVH
// Register indices; byte address is index times four
`define ELD_IDX_ID 4'h0
`define ELD_IDX_POWER 4'h1
`define ELD_IDX_LAMP 4'h2
`define ELD_IDX_SHAPE 4'h3
`define ELD_IDX_BOOST 4'h4
`define ELD_IDX_AUDIO 4'h5
`define ELD_IDX_CH0 4'h6
`define ELD_IDX_CH3 4'h9
`define ELD_IDX_UPDATE 4'ha
// Field positions
`define ELD_EN_BIT 0
`define ELD_OVT_BIT 7
`define ELD_DAMP_BIT 6
`define ELD_PWM_BIT 7
`define ELD_SS_LSB 6
// Reset values
`define ELD_REG_RST 8'h00
`define ELD_ID_VALUE 8'h5a
// Timing and scaling
`define ELD_CLK_HZ 20000000
`define ELD_LAMP_K 170
`define ELD_BOOST_K 22
`define ELD_RAMP_SHIFT 10
`define ELD_VPP_MAX 300
`define ELD_AUX_V_STEP 5
`define ELD_AMP_FULL 31
`endif

/* File: eld_pkg.sv */
// Types shared by the lamp driver control core
package eld_pkg;
    // Per-channel staged or applied setting
    typedef struct packed {
        logic [2:0] channel_ramp_rate_code;
        logic [4:0] channel_amplitude_code;
    } eld_chan_cfg_t;

    // Audio effects configuration
    typedef struct packed {
        logic modulation_select;
        logic direct_follow;
        logic audio_divider_hi;
        logic audio_divider_lo;
        logic [3:0] audio_select;
    } eld_audio_cfg_t;

    // Waveform selection
    typedef enum logic [1:0] {ELD_SHAPE_SINE, ELD_SHAPE_1, ELD_SHAPE_2, ELD_SHAPE_3} eld_shape_t;
endpackage

/* File: eld_core.sv */
// Lamp driver control core: register slave, ramping, oscillators and audio effects
//
// What this block does
// - One lamp frequency for all four channels from one 8-bit setting.
// - Each channel holds its own independent 5-bit amplitude code.
// - Each channel holds its own 3-bit ramp rate code.
// - Lamp frequency rises linearly within each octave of the frequency setting, doubling per octave.
// - Amplitude code maps linearly onto zero to full-scale peak-to-peak.
// - New targets are approached gradually at the channel's ramp pace.
// - Shutdown ramps each channel not in direct follow down to zero; direct follow channels drop to zero at once.
// - Boost oscillator set by 5-bit field, linear over low four bits.
// - Two-bit field selects spread-spectrum modulation of the boost oscillator.
// - Two-bit slope field sets output slope from sine to square.
// - In sine mode, highest channel gets full sine, others clamped.
// - Audio input modulates amplitude when select is 0, frequency when 1.
// - Amplitude mode with direct follow: selected channels track audio directly.
// - Steady audio level gives 250 V per volt, capped at 300 V.
// - Pulse-width audio gives amplitude proportional to duty, full duty 300 V.
// - Direct follow is ignored while frequency modulation is selected.
// - Frequency mode divides audio rate; host sets all four select bits.
// - Reset pin low clears all registers, shuts down, ignores bus writes.
// - Clearing enable shuts outputs but keeps register contents.
// - Overtemperature latches off; only reset pin low clears it.
// - Channel settings apply only after the update-all command.
// - Top two frequency bits pick octave, low six bits linear within.
// - Boost range bit 0 gives 800-1600 kHz, 1 gives 400-800 kHz.
`timescale 1ns/100ps
`include "eld_defines.svh"

module eld_core
    import eld_pkg::*;
#(
    parameter logic [7:0] ID_VALUE = `ELD_ID_VALUE // Arbitrary identity value
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [5:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic reset_pin_n_in,
    input wire logic overtemp_in,
    input wire logic aux_in,
    input wire logic [7:0] aux_level_in,
    output logic [3:0][8:0] chan_vpp_out,
    output logic [3:0] chan_clamp_out,
    output logic lamp_phase_out,
    output logic boost_gate_out,
    output logic [1:0] slope_select_out,
    output logic [1:0] shape_out,
    output logic damp_out,
    output logic lamp_on_out
);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [1:0] rpin_sync;
    logic [1:0] ovt_sync;
    logic [1:0] aux_sync;
    logic aux_d;

    // Two flops each; only the second stage is read
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rpin_sync <= 2'h0;
            ovt_sync <= 2'h0;
            aux_sync <= 2'h0;
            aux_d <= 1'b0;
        end else begin
            rpin_sync <= {rpin_sync[0], reset_pin_n_in};
            ovt_sync <= {ovt_sync[0], overtemp_in};
            aux_sync <= {aux_sync[0], aux_in};
            aux_d <= aux_sync[1];
        end
    end

    logic rpin_ok;
    logic aux_s;
    assign rpin_ok = rpin_sync[1];
    assign aux_s = aux_sync[1];

    // ************************************************
    // Register file
    // ************************************************
    logic en;
    logic ovt;
    logic [7:0] lamp_freq_setting;
    logic [7:0] shape_reg;
    logic [7:0] boost_reg;
    eld_audio_cfg_t audio;
    eld_chan_cfg_t [3:0] staged;
    eld_chan_cfg_t [3:0] applied;

    logic [3:0] idx;
    logic wr_fire;
    logic rd_fire;
    assign idx = address_in[5:2];
    // Request completes at the edge where waitrequest is low
    assign wr_fire = write_in && !waitrequest_out && rpin_ok && byteenable_in[0];
    assign rd_fire = read_in && waitrequest_out;

    // Reset pin clears everything and beats any write or update
    always_ff @(posedge clk_in) begin
        if (srst_in || !rpin_ok) begin
            en <= 1'b0;
            lamp_freq_setting <= `ELD_REG_RST;
            shape_reg <= `ELD_REG_RST;
            boost_reg <= `ELD_REG_RST;
            audio <= eld_audio_cfg_t'(`ELD_REG_RST);
            staged <= '0;
            applied <= '0;
        end else if (wr_fire) begin
            unique case (idx)
                `ELD_IDX_POWER: en <= writedata_in[`ELD_EN_BIT];
                `ELD_IDX_LAMP: lamp_freq_setting <= writedata_in[7:0];
                `ELD_IDX_SHAPE: shape_reg <= writedata_in[7:0];
                `ELD_IDX_BOOST: boost_reg <= writedata_in[7:0];
                `ELD_IDX_AUDIO: audio <= eld_audio_cfg_t'(writedata_in[7:0]);
                4'h6, 4'h7, 4'h8, 4'h9: staged[2'(idx - `ELD_IDX_CH0)] <= writedata_in[7:0];
                `ELD_IDX_UPDATE: applied <= staged;
                default: ;
            endcase
        end
    end

    // Overtemperature latch; reset pin low is the only way out
    always_ff @(posedge clk_in) begin
        if (srst_in || !rpin_ok) begin
            ovt <= 1'b0;
        end else if (ovt_sync[1]) begin
            ovt <= 1'b1;
        end
    end

    // ************************************************
    // Avalon slave answer
    // ************************************************
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            `ELD_IDX_ID: rd_byte = ID_VALUE;
            `ELD_IDX_POWER: rd_byte = {ovt, 6'h00, en};
            `ELD_IDX_LAMP: rd_byte = lamp_freq_setting;
            `ELD_IDX_SHAPE: rd_byte = shape_reg;
            `ELD_IDX_BOOST: rd_byte = boost_reg;
            `ELD_IDX_AUDIO: rd_byte = audio;
            4'h6, 4'h7, 4'h8, 4'h9: rd_byte = staged[2'(idx - `ELD_IDX_CH0)];
            default: rd_byte = 8'h00;
        endcase
        if (!rpin_ok) begin
            rd_byte = 8'h00;
        end
    end

    // One wait cycle per request; idle waitrequest sits high
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            waitrequest_out <= 1'b1;
            readdata_out <= 32'h0;
        end else begin
            waitrequest_out <= !((read_in || write_in) && waitrequest_out);
            if (rd_fire) begin
                readdata_out <= {24'h0, rd_byte};
            end
        end
    end

    // ************************************************
    // Run state and shape controls
    // ************************************************
    logic run;
    assign run = en && !ovt && rpin_ok;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lamp_on_out <= 1'b0;
            slope_select_out <= 2'h0;
            shape_out <= 2'h0;
            damp_out <= 1'b0;
        end else begin
            lamp_on_out <= run;
            slope_select_out <= shape_reg[1:0];
            shape_out <= shape_reg[3:2];
            damp_out <= shape_reg[`ELD_DAMP_BIT];
        end
    end

    // ************************************************
    // Amplitude ramping
    // ************************************************
    logic [3:0][4:0] cur;
    logic [3:0][17:0] ramp_tmr;

    // Step size is one code; step interval doubles with each ramp rate code
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cur <= '0;
            ramp_tmr <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                logic [4:0] tgt;
                logic [17:0] lim;
                tgt = run ? applied[i].channel_amplitude_code : 5'h00;
                lim = 18'((18'h1 << (`ELD_RAMP_SHIFT + applied[i].channel_ramp_rate_code)) - 18'h1);
                if (cur[i] == tgt) begin
                    ramp_tmr[i] <= 18'h0;
                end else if (ramp_tmr[i] >= lim) begin
                    ramp_tmr[i] <= 18'h0;
                    cur[i] <= (cur[i] < tgt) ? 5'(cur[i] + 5'h1) : 5'(cur[i] - 5'h1);
                end else begin
                    ramp_tmr[i] <= 18'(ramp_tmr[i] + 18'h1);
                end
            end
        end
    end

    // ************************************************
    // Audio input measurement
    // ************************************************
    logic [7:0] pwm_win;
    logic [8:0] pwm_hi;
    logic [8:0] pwm_duty;

    // Duty measured over a 256-cycle window; coarse for fast PWM
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pwm_win <= 8'h0;
            pwm_hi <= 9'h0;
            pwm_duty <= 9'h0;
        end else begin
            pwm_win <= 8'(pwm_win + 8'h1);
            if (pwm_win == 8'hff) begin
                pwm_duty <= 9'(pwm_hi + {8'h0, aux_s});
                pwm_hi <= 9'h0;
            end else begin
                pwm_hi <= 9'(pwm_hi + {8'h0, aux_s});
            end
        end
    end

    logic [8:0] aux_vpp;
    logic [17:0] pwm_prod;
    logic [11:0] lvl_prod;

    // Scaled audio amplitude, either from duty or from the level
    always_comb begin
        pwm_prod = 18'(pwm_duty * 18'(`ELD_VPP_MAX));
        lvl_prod = 12'(aux_level_in * 12'(`ELD_AUX_V_STEP));
        if (shape_reg[`ELD_PWM_BIT]) begin
            aux_vpp = 9'(pwm_prod >> 8);
        end else if (lvl_prod > 12'(`ELD_VPP_MAX)) begin
            aux_vpp = 9'(`ELD_VPP_MAX);
        end else begin
            aux_vpp = 9'(lvl_prod);
        end
    end

    // ************************************************
    // Channel outputs
    // ************************************************
    logic [4:0] max_code;

    // Largest ramped amplitude, used for sine clamping
    always_comb begin
        max_code = 5'h00;
        for (int i = 0; i < 4; i++) begin
            if (cur[i] > max_code) begin
                max_code = cur[i];
            end
        end
    end

    // Linear code to volts; follow mode bypasses the code
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            chan_vpp_out <= '0;
            chan_clamp_out <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                logic follow;
                follow = !audio.modulation_select && audio.direct_follow && audio.audio_select[i];
                if (follow) begin
                    chan_vpp_out[i] <= run ? aux_vpp : 9'h0;
                end else begin
                    chan_vpp_out[i] <= 9'(14'(cur[i] * 14'(`ELD_VPP_MAX)) / 14'(`ELD_AMP_FULL));
                end
                chan_clamp_out[i] <= (shape_reg[3:2] == ELD_SHAPE_SINE) && (cur[i] < max_code);
            end
        end
    end

    // ************************************************
    // Lamp oscillator and frequency modulation
    // ************************************************
    logic [31:0] lamp_acc;
    logic [17:0] lamp_inc;
    logic [1:0] fm_cnt;
    logic fm_phase;
    logic fm_on;

    // Octave doubles the step; low six bits scale it linearly
    assign lamp_inc = 18'((15'(7'd63 + 7'(lamp_freq_setting[5:0])) * 15'(`ELD_LAMP_K))
        << lamp_freq_setting[7:6]);
    // Frequency mode needs every channel routed to audio
    assign fm_on = audio.modulation_select && (audio.audio_select == 4'hf);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lamp_acc <= 32'h0;
        end else begin
            lamp_acc <= 32'(lamp_acc + {14'h0, lamp_inc});
        end
    end

    // Each divided audio edge flips the lamp phase
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fm_cnt <= 2'h0;
            fm_phase <= 1'b0;
        end else if (aux_s != aux_d) begin
            if (fm_cnt == {audio.audio_divider_hi, audio.audio_divider_lo}) begin
                fm_cnt <= 2'h0;
                fm_phase <= !fm_phase;
            end else begin
                fm_cnt <= 2'(fm_cnt + 2'h1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lamp_phase_out <= 1'b0;
        end else begin
            lamp_phase_out <= run && (fm_on ? fm_phase : lamp_acc[31]);
        end
    end

    // ************************************************
    // Boost oscillator with spread spectrum
    // ************************************************
    // 14-bit phase: steps of 330 to 1320, plus up to 31 of dither, give roughly 400 kHz to 1.6 MHz at 20 MHz
    logic [13:0] boost_acc;
    logic [14:0] boost_sum;
    logic [11:0] boost_inc;
    logic [4:0] tri_val;
    logic tri_up;
    logic [2:0] ss_pre;
    logic [1:0] ss_sel;
    logic [2:0] ss_mask;

    assign ss_sel = boost_reg[`ELD_SS_LSB +: 2];
    assign ss_mask = 3'((4'h1 << ss_sel) - 4'h1);
    // Range bit 0 doubles the step for the upper band
    assign boost_inc = 12'((10'(5'd15 + 5'(boost_reg[3:0])) * 10'(`ELD_BOOST_K))
        << !boost_reg[4]) + 12'(ss_sel != 2'h0 ? tri_val : 5'h0);
    assign boost_sum = {1'b0, boost_acc} + {3'h0, boost_inc};

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            boost_acc <= 14'h0;
            boost_gate_out <= 1'b0;
        end else begin
            boost_acc <= boost_sum[13:0];
            boost_gate_out <= run && boost_acc[13];
        end
    end

    // Triangle dither steps once per 2^ss boost cycles
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tri_val <= 5'h0;
            tri_up <= 1'b1;
            ss_pre <= 3'h0;
        end else if (boost_sum[14]) begin
            ss_pre <= 3'(ss_pre + 3'h1);
            if (ss_sel != 2'h0 && (ss_pre & ss_mask) == ss_mask) begin
                if (tri_up) begin
                    tri_val <= 5'(tri_val + 5'h1);
                    tri_up <= (tri_val != 5'h1e);
                end else begin
                    tri_val <= 5'(tri_val - 5'h1);
                    tri_up <= (tri_val == 5'h01);
                end
            end
        end
    end

endmodule // eld_core

/* File: eld_core_chk.sv */
// Concurrent checks on the lamp driver control core ports
`timescale 1ns/100ps
module eld_core_chk
    import eld_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] readdata_out,
    input wire logic waitrequest_out,
    input wire logic reset_pin_n_in,
    input wire logic overtemp_in,
    input wire logic [3:0][8:0] chan_vpp_out,
    input wire logic [3:0] chan_clamp_out,
    input wire logic lamp_phase_out,
    input wire logic boost_gate_out,
    input wire logic lamp_on_out
);
    // ****************
    // Bus and outputs
    // ****************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wait_one_a: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
        else $error("bus answer late");
    wait_pulse_a: assert property (!waitrequest_out |=> waitrequest_out)
        else $error("waitrequest low too long");
    read_upper_a: assert property (read_in && !waitrequest_out |-> readdata_out[31:8] == 24'h0)
        else $error("read upper bits set");
    vpp_cap_a: assert property (chan_vpp_out[0] <= 9'd300 && chan_vpp_out[1] <= 9'd300
        && chan_vpp_out[2] <= 9'd300 && chan_vpp_out[3] <= 9'd300)
        else $error("amplitude above full scale");
    // Channel 0 is never driven in follow mode, so steps must be spaced
    ramp_space_a: assert property ($changed(chan_vpp_out[0]) |=> $stable(chan_vpp_out[0])[*8])
        else $error("amplitude moved abruptly");
    off_quiet_a: assert property (!lamp_on_out [*3] |-> !boost_gate_out && !lamp_phase_out)
        else $error("switching while off");
    ovt_off_a: assert property (overtemp_in [*6] |-> !lamp_on_out)
        else $error("running in overtemperature");
    pin_off_a: assert property (!reset_pin_n_in [*4] |-> !lamp_on_out)
        else $error("running with reset pin low");
    pin_read_a: assert property (!reset_pin_n_in [*4] ##1 (read_in && !waitrequest_out) |-> readdata_out == 32'h0)
        else $error("register not cleared by pin");
    // Main scenarios
    wr_c: cover property (write_in && !waitrequest_out);
    ramp_c: cover property ($changed(chan_vpp_out[0]));
    clamp_c: cover property (chan_clamp_out[1] && lamp_on_out);
    phase_c: cover property ($rose(lamp_phase_out));
endmodule // eld_core_chk
bind eld_core eld_core_chk chk_u (.clk_in(clk_in), .srst_in(srst_in), .read_in(read_in), .write_in(write_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .reset_pin_n_in(reset_pin_n_in),
    .overtemp_in(overtemp_in), .chan_vpp_out(chan_vpp_out), .chan_clamp_out(chan_clamp_out),
    .lamp_phase_out(lamp_phase_out), .boost_gate_out(boost_gate_out), .lamp_on_out(lamp_on_out));

/* File: eld_aux_src.sv */
// Behavioural audio source driving the auxiliary pin
`timescale 1ns/100ps
module eld_aux_src (
    input wire logic run_in,
    input wire logic [8:0] high_ns_in,
    output logic aux_out
);
    // ****************
    // Pulse generator
    // ****************
    // 400 ns period, 2.5 MHz, inside the pulse-width band; idle holds low
    initial begin
        aux_out = 1'b0;
        #13;
        forever begin
            if (run_in) begin
                aux_out = 1'b1;
                #(high_ns_in);
                aux_out = 1'b0;
                #(400 - high_ns_in);
            end else begin
                #50;
            end
        end
    end
endmodule // eld_aux_src

/* File: test_eld_core.sv */
// Self-checking testbench for the lamp driver control core
`timescale 1ns/100ps
module test_eld_core
    import eld_pkg::*;
;
    logic clk_in = 1'b0, srst_in = 1'b1, read_in = 1'b0, write_in = 1'b0;
    logic [5:0] address_in = 6'h00;
    logic [31:0] writedata_in = 32'h0, readdata_out, q;
    logic [3:0] byteenable_in = 4'hf, chan_clamp_out;
    logic waitrequest_out, reset_pin_n_in = 1'b1, overtemp_in = 1'b0, aux_in, aux_run = 1'b0;
    logic [7:0] aux_level_in = 8'h00;
    logic [8:0] high_ns = 9'd200;
    logic [3:0][8:0] chan_vpp_out;
    logic lamp_phase_out, boost_gate_out, damp_out, lamp_on_out;
    logic [1:0] slope_select_out, shape_out;
    int fail_count = 0, checked = 0, n;
    // ****************
    // Clock, design, far side
    // ****************
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    eld_core #(.ID_VALUE(8'h3c)) dut_u (.clk_in(clk_in), .srst_in(srst_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .reset_pin_n_in(reset_pin_n_in),
        .overtemp_in(overtemp_in), .aux_in(aux_in), .aux_level_in(aux_level_in), .chan_vpp_out(chan_vpp_out),
        .chan_clamp_out(chan_clamp_out), .lamp_phase_out(lamp_phase_out), .boost_gate_out(boost_gate_out),
        .slope_select_out(slope_select_out), .shape_out(shape_out), .damp_out(damp_out),
        .lamp_on_out(lamp_on_out));
    eld_aux_src aux_u (.run_in(aux_run), .high_ns_in(high_ns), .aux_out(aux_in));
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    // Holds the request until waitrequest is sampled low; data taken there
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int k;
        @(posedge clk_in);
        address_in <= {idx, 2'b00};
        write_in <= w;
        read_in <= !w;
        writedata_in <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (waitrequest_out !== 1'b0 && k < 50);
        if (k >= 50) fail_count++;
        q = readdata_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(q, {24'h0, exp});
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_in);
    endtask
    // Bounded wait for a channel to settle; returns cycles taken in n
    task automatic wait_vpp(input int ch, input logic [8:0] v, input int lim);
        n = 0;
        while (chan_vpp_out[ch] !== v && n < lim) begin
            @(posedge clk_in);
            n++;
        end
        chk(chan_vpp_out[ch], v);
    endtask
    task automatic complete_run;
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset_vals;
        chk(waitrequest_out, 1'b1);
        rd(4'h0, 8'h3c);
        for (int i = 1; i < 10; i++) rd(i[3:0], 8'h00);
        rd(4'hc, 8'h00);
    endtask
    task automatic t_regs;
        bus(1'b1, 4'h2, 8'hc5);
        rd(4'h2, 8'hc5);
        bus(1'b1, 4'h3, 8'h4e);
        cyc(3);
        chk({damp_out, shape_out, slope_select_out}, 5'h1e);
        bus(1'b1, 4'h4, 8'hdf);
        rd(4'h4, 8'hdf);
        byteenable_in <= 4'he;
        bus(1'b1, 4'h2, 8'h11);
        byteenable_in <= 4'hf;
        rd(4'h2, 8'hc5);
        for (int i = 0; i < 4; i++) bus(1'b1, 4'h6 + i[3:0], {i[2:0], 5'h03 + 5'(i * 7)});
        for (int i = 0; i < 4; i++) rd(4'h6 + i[3:0], {i[2:0], 5'h03 + 5'(i * 7)});
    endtask
    task automatic t_ramp;
        bus(1'b1, 4'h3, 8'h00);
        bus(1'b1, 4'h2, 8'h00);
        bus(1'b1, 4'h1, 8'h01);
        bus(1'b1, 4'h6, 8'h08);
        bus(1'b1, 4'h7, 8'h23);
        cyc(20);
        chk(chan_vpp_out[0], 9'd0);
        bus(1'b1, 4'ha, 8'h00);
        cyc(100);
        chk(chan_vpp_out[0] < 9'd77, 1'b1);
        wait_vpp(1, 9'd29, 9000);
        chk(n > 5000 && n < 7000, 1'b1);
        wait_vpp(0, 9'd77, 5000);
        chk(chan_clamp_out[1:0], 2'b10);
        bus(1'b1, 4'h1, 8'h00);
        cyc(50);
        chk(lamp_on_out, 1'b0);
        chk(chan_vpp_out[0] != 9'd0, 1'b1);
        rd(4'h6, 8'h08);
        wait_vpp(0, 9'd0, 12000);
    endtask
    task automatic t_direct;
        bus(1'b1, 4'h1, 8'h01);
        bus(1'b1, 4'h5, 8'h44);
        aux_level_in <= 8'd20;
        wait_vpp(2, 9'd100, 50);
        aux_level_in <= 8'd80;
        wait_vpp(2, 9'd300, 50);
        bus(1'b1, 4'h3, 8'hce);
        high_ns <= 9'd100;
        aux_run <= 1'b1;
        cyc(600);
        chk(chan_vpp_out[2] >= 9'd60 && chan_vpp_out[2] <= 9'd90, 1'b1);
    endtask
    task automatic t_fm;
        int flips;
        int bflips;
        logic last;
        logic blast;
        high_ns <= 9'd200;
        bus(1'b1, 4'h5, 8'hdf);
        cyc(40);
        flips = 0;
        bflips = 0;
        last = lamp_phase_out;
        blast = boost_gate_out;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_in);
            if (lamp_phase_out !== last) flips++;
            if (boost_gate_out !== blast) bflips++;
            last = lamp_phase_out;
            blast = boost_gate_out;
        end
        chk(flips >= 8 && flips <= 12, 1'b1);
        // Low band top setting: about 800 kHz, 25 clocks a period, so 5 to 8 toggles
        chk(bflips >= 5 && bflips <= 8, 1'b1);
        aux_run <= 1'b0;
    endtask
    task automatic t_ovt;
        overtemp_in <= 1'b1;
        cyc(8);
        overtemp_in <= 1'b0;
        cyc(5);
        chk(lamp_on_out, 1'b0);
        bus(1'b0, 4'h1, 8'h00);
        chk(q[7], 1'b1);
        bus(1'b1, 4'h1, 8'h01);
        cyc(5);
        chk(lamp_on_out, 1'b0);
        reset_pin_n_in <= 1'b0;
        cyc(5);
        bus(1'b1, 4'h6, 8'h1f);
        bus(1'b1, 4'h1, 8'h01);
        bus(1'b1, 4'ha, 8'h00);
        rd(4'h6, 8'h00);
        reset_pin_n_in <= 1'b1;
        cyc(5);
        rd(4'h1, 8'h00);
        rd(4'h6, 8'h00);
        chk(lamp_on_out, 1'b0);
    endtask
    // ****************
    // Sequence and watchdog
    // ****************
    initial begin
        cyc(10);
        srst_in <= 1'b0;
        @(posedge clk_in);
        t_reset_vals();
        t_regs();
        t_ramp();
        t_direct();
        t_fm();
        t_ovt();
        complete_run();
    end
    // About 20000 cycles expected; allow three times that
    initial begin
        #(60000 * 50);
        fail_count++;
        complete_run();
    end
endmodule // test_eld_core
